// ---- ajbel_pkg.sv ----
package ajbel_pkg;

  localparam int          CLK_HZ          = 40_000_000;
  localparam int          TRIP_HOLD_MS    = 20;
  localparam int          TRIP_HOLD_CYC   = CLK_HZ / 1000 * TRIP_HOLD_MS;
  localparam int          BLOCK_LEAD_MS   = 5;
  localparam int          LOG_DEPTH       = 12;
  localparam int          NUM_CH          = 4;
  localparam int          ANG_W           = 16;
  localparam int          RATIO_W         = 16;
  localparam int          TS_W            = 64;
  localparam int          CNT_W           = 16;
  localparam logic [15:0] UV_LIMIT_RESET  = 16'h251c;

  typedef enum logic [1:0] {
    AJBEL_NORMAL,
    AJBEL_BLOCKED,
    AJBEL_TRIP,
    AJBEL_ALARM
  } ajbel_cond_t;

  typedef enum logic [2:0] {
    AJBEL_MODE_ON,
    AJBEL_MODE_BLOCKED,
    AJBEL_MODE_TEST,
    AJBEL_MODE_TEST_BLOCKED,
    AJBEL_MODE_OFF
  } ajbel_mode_t;

  localparam logic [2:0] EV_BLOCK_ON  = 3'h0;
  localparam logic [2:0] EV_BLOCK_OFF = 3'h1;
  localparam logic [2:0] EV_TRIP_ON   = 3'h2;
  localparam logic [2:0] EV_TRIP_OFF  = 3'h3;
  localparam logic [2:0] EV_ALARM_ON  = 3'h4;
  localparam logic [2:0] EV_ALARM_OFF = 3'h5;

  // Log word: time, event, channel, channel 0 angle difference, channel 1 angle difference, group
  localparam int LOG_W = TS_W + 3 + 3 + ANG_W + ANG_W + 3;

endpackage : ajbel_pkg

// ---- ajbel_log_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module ajbel_log_mem #(
  parameter int DEPTH = 12,
  parameter int W     = 8,
  parameter int AW    = 4
) (
  input  wire logic          clk_sys,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : ajbel_log_mem
`default_nettype wire

// ---- ajbel_top.sv ----
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ajbel_top
  import ajbel_pkg::*;
#(
  parameter int TRIP_HOLD = TRIP_HOLD_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic                        cycle_start,
  input  wire logic                        block_in,
  input  wire logic                        trip_pickup,
  input  wire logic                        alarm_pickup,
  input  wire logic [NUM_CH-1:0]           ch_select,
  input  wire logic [NUM_CH-1:0]           ch_present,
  input  wire logic [NUM_CH*ANG_W-1:0]     ang_now,
  input  wire logic [NUM_CH*ANG_W-1:0]     ang_20ms,
  input  wire logic [NUM_CH*16-1:0]        volt_meas,
  input  wire logic [TS_W-1:0]             time_stamp,
  input  wire logic [2:0]                  setting_group,
  input  wire logic                        allow_node_mode,
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  output logic                             trip_out,
  output logic                             alarm_out,
  output logic                             blocked_out,
  output logic                             irq,
  output logic                             event_valid,
  output logic      [2:0]                  event_code,
  output logic      [TS_W-1:0]             event_time,
  output logic      [1:0]                  condition,
  output logic                             volt_sel_ok,
  output logic      [2:0]                  node_mode,
  output logic                             node_mode_valid,
  output logic      [NUM_CH*ANG_W-1:0]     ang_diff,
  output logic      [NUM_CH*RATIO_W-1:0]   volt_ratio
);
  // Register map
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_UVLIM  = 4'h1;
  localparam logic [3:0] A_EVSEL  = 4'h2;
  localparam logic [3:0] A_STAT   = 4'h3;
  localparam logic [3:0] A_MASK   = 4'h4;
  localparam logic [3:0] A_CNTA   = 4'h5;
  localparam logic [3:0] A_CNTT   = 4'h6;
  localparam logic [3:0] A_CNTB   = 4'h7;
  localparam logic [3:0] A_CLR    = 4'h8;
  localparam logic [3:0] A_LOGIDX = 4'h9;
  localparam logic [3:0] A_LOGLO  = 4'ha;
  localparam logic [3:0] A_LOGHI  = 4'hb;
  localparam logic [3:0] A_LOGAUX = 4'hc;
  localparam logic [3:0] A_LOGCNT = 4'hd;
  localparam logic [3:0] A_LOGTAG = 4'hf;
  localparam int         AW       = $clog2(LOG_DEPTH);
  localparam int         HOLD_W   = $clog2(TRIP_HOLD + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic                   alarm_en_q;
  logic [2:0]             mode_q;
  logic [15:0]            uv_lim_q;
  logic [11:0]            ev_sel_q;
  logic [2:0]             mask_q;
  logic [AW-1:0]          log_idx_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      alarm_en_q <= 1'b0;
      mode_q     <= 3'h0;
      uv_lim_q   <= UV_LIMIT_RESET;
      ev_sel_q   <= 12'hfff;
      mask_q     <= 3'h0;
      log_idx_q  <= '0;
    end else if (reg_wr) begin
      if (reg_addr == A_CTRL) begin
        alarm_en_q <= reg_wdata[0];
        mode_q     <= reg_wdata[6:4];
      end
      if (reg_addr == A_UVLIM)  uv_lim_q  <= reg_wdata[15:0];
      if (reg_addr == A_EVSEL)  ev_sel_q  <= reg_wdata[11:0];
      if (reg_addr == A_MASK)   mask_q    <= reg_wdata[2:0];
      if (reg_addr == A_LOGIDX) log_idx_q <= reg_wdata[AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the external pick-up and block levels
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {block_in, trip_pickup, alarm_pickup};
      sync2_q <= sync1_q;
    end
  end
  wire blk_pin = sync2_q[2];
  wire tpu     = sync2_q[1];
  wire apu     = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Live measurements: angle difference and voltage ratio per channel
  wire [NUM_CH-1:0] under_v;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire [ANG_W-1:0] a_now = ang_now[g*ANG_W +: ANG_W];
      wire [ANG_W-1:0] a_old = ang_20ms[g*ANG_W +: ANG_W];
      wire [15:0]      v     = volt_meas[g*16 +: 16];
      wire [31:0]      num   = {16'h0000, v} * 32'd100;
      wire [31:0]      rat   = (uv_lim_q == 16'h0000) ? 32'h0000ffff : num / {16'h0000, uv_lim_q};
      assign under_v[g] = ch_select[g] && (v < uv_lim_q);
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          ang_diff[g*ANG_W +: ANG_W]       <= '0;
          volt_ratio[g*RATIO_W +: RATIO_W] <= '0;
        end else begin
          ang_diff[g*ANG_W +: ANG_W]       <= a_now - a_old;
          volt_ratio[g*RATIO_W +: RATIO_W] <= (rat > 32'h0000ffff) ? 16'hffff : rat[15:0];
        end
      end
    end
  endgenerate

  wire sel_ok = (ch_select != '0) && ((ch_select & ~ch_present) == '0);
  wire mode_blk = (mode_q == AJBEL_MODE_BLOCKED) || (mode_q == AJBEL_MODE_TEST_BLOCKED);
  wire mode_off = (mode_q == AJBEL_MODE_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle-start block sampling and pick-up decision
  logic              blk_q;
  logic              tpu_q;
  logic              apu_q;
  logic              trip_q;
  logic              alarm_q;
  logic              blkd_q;
  logic [HOLD_W-1:0] hold_q;

  // The block level is frozen per cycle so a late blocker cannot half-apply
  wire blk_eff   = blk_q || (under_v != '0) || mode_blk;
  wire tpu_rise  = tpu && !tpu_q;
  wire apu_rise  = apu && !apu_q && alarm_en_q;
  wire pu_rise   = (tpu_rise || apu_rise) && !mode_off;
  wire do_trip   = tpu_rise && !blk_eff && !mode_off;
  wire do_alarm  = apu_rise && !blk_eff && !mode_off;
  wire do_blkd   = pu_rise && blk_eff;
  wire hold_done = trip_q && (hold_q == HOLD_W'(TRIP_HOLD - 1));
  wire alarm_off = alarm_q && (!apu || !alarm_en_q);
  wire blkd_off  = blkd_q && !tpu && !apu;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      blk_q   <= 1'b0;
      tpu_q   <= 1'b0;
      apu_q   <= 1'b0;
      trip_q  <= 1'b0;
      alarm_q <= 1'b0;
      blkd_q  <= 1'b0;
      hold_q  <= '0;
    end else begin
      if (cycle_start) blk_q <= blk_pin;
      tpu_q <= tpu;
      apu_q <= apu;
      if (do_trip) begin
        trip_q <= 1'b1;
        hold_q <= '0;
      end else if (hold_done) begin
        trip_q <= 1'b0;
      end else if (trip_q) begin
        hold_q <= hold_q + HOLD_W'(1);
      end
      if (do_alarm) alarm_q <= 1'b1;
      else if (alarm_off) alarm_q <= 1'b0;
      if (do_blkd) blkd_q <= 1'b1;
      else if (blkd_off) blkd_q <= 1'b0;
    end
  end

  assign trip_out    = trip_q;
  assign alarm_out   = alarm_q;
  assign blocked_out = blkd_q;
  assign condition   = trip_q ? AJBEL_TRIP : alarm_q ? AJBEL_ALARM :
                       blkd_q ? AJBEL_BLOCKED : AJBEL_NORMAL;
  assign volt_sel_ok = sel_ok;
  assign node_mode       = allow_node_mode ? mode_q : 3'h0;
  assign node_mode_valid = allow_node_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Events: ON/OFF edges filtered per event; the lowest event code has priority in one cycle
  wire [5:0] ev_raw = {alarm_off, do_alarm, hold_done, do_trip, blkd_off, do_blkd};
  wire [5:0] ev_hit = ev_raw & {ev_sel_q[11], ev_sel_q[8], ev_sel_q[7], ev_sel_q[4], ev_sel_q[3], ev_sel_q[0]};

  function automatic logic [2:0] ajbel_first(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction : ajbel_first

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      event_valid <= 1'b0;
      event_code  <= 3'h0;
      event_time  <= '0;
    end else begin
      event_valid <= (ev_hit != 6'h00);
      event_code  <= ajbel_first(ev_hit);
      event_time  <= time_stamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters, sticky status and interrupt
  logic [CNT_W-1:0] cnt_a_q;
  logic [CNT_W-1:0] cnt_t_q;
  logic [CNT_W-1:0] cnt_b_q;
  logic [2:0]       stat_q;

  wire       clr_wr  = reg_wr && (reg_addr == A_CLR);
  wire       stat_wr = reg_wr && (reg_addr == A_STAT);
  wire [2:0] stat_ev = {do_blkd, do_trip, do_alarm};

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_a_q <= '0;
      cnt_t_q <= '0;
      cnt_b_q <= '0;
      stat_q  <= 3'h0;
    end else begin
      cnt_a_q <= (clr_wr && reg_wdata[0]) ? '0 : cnt_a_q + CNT_W'(do_alarm);
      cnt_t_q <= (clr_wr && reg_wdata[1]) ? '0 : cnt_t_q + CNT_W'(do_trip);
      cnt_b_q <= (clr_wr && reg_wdata[2]) ? '0 : cnt_b_q + CNT_W'(do_blkd);
      stat_q  <= (stat_q & ~(stat_wr ? reg_wdata[2:0] : 3'h0)) | stat_ev;
    end
  end
  assign irq = (stat_q & mask_q) != 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Circular fault log
  logic [AW-1:0]    wptr_q;
  logic [AW:0]      fill_q;
  logic [LOG_W-1:0] log_rd;

  wire log_wr = do_trip || do_alarm || do_blkd;
  wire [2:0] log_ev = do_trip ? EV_TRIP_ON : do_alarm ? EV_ALARM_ON : EV_BLOCK_ON;
  function automatic logic [2:0] ajbel_chan(input logic [NUM_CH-1:0] s);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (s[i]) r = 3'(i);
    end
    return r;
  endfunction : ajbel_chan
  wire [2:0] log_ch = ajbel_chan(ch_select & (under_v | ch_present));
  wire [LOG_W-1:0] log_wd = {time_stamp, log_ev, log_ch, ang_diff[0 +: ANG_W],
                             ang_diff[ANG_W +: ANG_W], setting_group};
  // Read index counts back from the newest entry
  wire [AW:0] rd_raw = {1'b0, wptr_q} + (AW+1)'(LOG_DEPTH) - {1'b0, log_idx_q} - (AW+1)'(1);
  wire [AW-1:0] rd_ptr = (rd_raw >= (AW+1)'(LOG_DEPTH)) ? AW'(rd_raw - (AW+1)'(LOG_DEPTH)) : rd_raw[AW-1:0];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wptr_q <= '0;
      fill_q <= '0;
    end else if (log_wr) begin
      wptr_q <= (wptr_q == AW'(LOG_DEPTH - 1)) ? '0 : wptr_q + AW'(1);
      if (fill_q != (AW+1)'(LOG_DEPTH)) fill_q <= fill_q + (AW+1)'(1);
    end
  end

  ajbel_log_mem #(
    .DEPTH(LOG_DEPTH),
    .W    (LOG_W),
    .AW   (AW)
  ) u_log (
    .clk_sys (clk_sys),
    .wr_en   (log_wr),
    .wr_addr (wptr_q),
    .wr_data (log_wd),
    .rd_addr (rd_ptr),
    .rd_data (log_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read port: one-cycle latency, unmapped addresses read zero
  logic [3:0] rd_addr_q;
  logic       rd_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_addr_q <= 4'h0;
      rd_q      <= 1'b0;
    end else begin
      rd_addr_q <= reg_addr;
      rd_q      <= reg_rd;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (rd_addr_q)
      A_CTRL:   rd_mux = {25'h0, mode_q, 3'h0, alarm_en_q};
      A_UVLIM:  rd_mux = {16'h0, uv_lim_q};
      A_EVSEL:  rd_mux = {20'h0, ev_sel_q};
      A_STAT:   rd_mux = {24'h0, volt_sel_ok, condition, 2'h0, stat_q};
      A_MASK:   rd_mux = {29'h0, mask_q};
      A_CNTA:   rd_mux = {16'h0, cnt_a_q};
      A_CNTT:   rd_mux = {16'h0, cnt_t_q};
      A_CNTB:   rd_mux = {16'h0, cnt_b_q};
      A_LOGIDX: rd_mux = {28'h0, log_idx_q};
      A_LOGLO:  rd_mux = log_rd[LOG_W-TS_W+:32];
      A_LOGHI:  rd_mux = log_rd[LOG_W-32+:32];
      A_LOGAUX: rd_mux = log_rd[3 +: 2*ANG_W];
      A_LOGCNT: rd_mux = {27'h0, fill_q};
      A_LOGTAG: rd_mux = {23'h0, log_rd[LOG_W-TS_W-1 -: 6], log_rd[2:0]};
      default:  rd_mux = 32'h0;
    endcase
  end
  assign reg_rdata = rd_q ? rd_mux : 32'h0;

endmodule : ajbel_top
`default_nettype wire

// ---- ajbel_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ajbel_checker
  import ajbel_pkg::*;
#(
  parameter int TRIP_HOLD = TRIP_HOLD_CYC
) (
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire logic                    reg_rd,
  input wire logic [31:0]             reg_rdata,
  input wire logic                    trip_out,
  input wire logic                    alarm_out,
  input wire logic                    blocked_out,
  input wire logic                    event_valid,
  input wire logic [2:0]              event_code,
  input wire logic [1:0]              condition,
  input wire logic                    allow_node_mode,
  input wire logic                    node_mode_valid,
  input wire logic [2:0]              node_mode,
  input wire logic [NUM_CH*ANG_W-1:0] ang_now,
  input wire logic [NUM_CH*ANG_W-1:0] ang_20ms,
  input wire logic [NUM_CH*ANG_W-1:0] ang_diff,
  input wire logic [TS_W-1:0]         time_stamp,
  input wire logic [TS_W-1:0]         event_time
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  logic [31:0]      hold_q;
  logic [ANG_W-1:0] diff0;
  assign diff0 = ang_now[ANG_W-1:0] - ang_20ms[ANG_W-1:0];
  // Counts the current trip pulse so its length can be judged at the fall
  always_ff @(posedge clk_sys) begin
    if (!rst_b) hold_q <= '0;
    else if (trip_out) hold_q <= hold_q + 32'h1;
    else hold_q <= '0;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_trip_rise; $rose(trip_out); endsequence
  sequence s_blk_rise; $rose(blocked_out); endsequence
  property p_trip_len; $fell(trip_out) |-> hold_q == TRIP_HOLD; endproperty
  property p_trip_max; trip_out |-> hold_q < TRIP_HOLD; endproperty
  property p_blk_only; s_blk_rise |-> !$rose(trip_out) && !$rose(alarm_out); endproperty
  property p_cond_trip; s_trip_rise |-> ##[0:2] condition == 2'h2; endproperty
  property p_cond_blk; s_blk_rise |-> ##[0:2] condition == 2'h1; endproperty
  property p_ev_trip; event_valid && event_code == EV_TRIP_ON |-> trip_out; endproperty
  property p_ev_blk; event_valid && event_code == EV_BLOCK_ON |-> blocked_out; endproperty
  property p_node; !allow_node_mode [*2] |-> !node_mode_valid && node_mode == 3'h0; endproperty
  property p_ang; ang_diff[ANG_W-1:0] == $past(diff0); endproperty
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  property p_ev_time; event_valid |-> event_time == $past(time_stamp); endproperty
  a_trip_len: assert property (p_trip_len) else $error("trip pulse length wrong");
  a_trip_max: assert property (p_trip_max) else $error("trip pulse too long");
  a_blk_only: assert property (p_blk_only) else $error("blocked pick-up raised trip or alarm");
  a_cond_trip: assert property (p_cond_trip) else $error("condition not trip");
  a_cond_blk: assert property (p_cond_blk) else $error("condition not blocked");
  a_ev_trip: assert property (p_ev_trip) else $error("trip on event without trip");
  a_ev_blk: assert property (p_ev_blk) else $error("block on event without block");
  a_node: assert property (p_node) else $error("node mode shown while disabled");
  a_ang: assert property (p_ang) else $error("angle difference wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_ev_time: assert property (p_ev_time) else $error("event time stamp wrong");
endmodule : ajbel_checker
bind ajbel_top ajbel_checker #(.TRIP_HOLD(TRIP_HOLD)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trip_out(trip_out), .alarm_out(alarm_out),
  .blocked_out(blocked_out), .event_valid(event_valid), .event_code(event_code), .condition(condition),
  .allow_node_mode(allow_node_mode), .node_mode_valid(node_mode_valid), .node_mode(node_mode),
  .ang_now(ang_now), .ang_20ms(ang_20ms), .ang_diff(ang_diff), .time_stamp(time_stamp),
  .event_time(event_time));
`default_nettype wire

// ---- ajbel_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module ajbel_partner #(
  parameter int LEAD   = 8,
  parameter int PERIOD = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic want_block,
  input  wire logic want_trip,
  input  wire logic want_alarm,
  output logic      cycle_start,
  output logic      block_in,
  output logic      trip_pickup,
  output logic      alarm_pickup
);
  logic [7:0]      cyc_q;
  logic [LEAD-1:0] trip_q;
  logic [LEAD-1:0] alarm_q;
  // Pick-ups lag the request by two program cycles so the block is seen ahead of them
  assign trip_pickup  = trip_q[LEAD-1];
  assign alarm_pickup = alarm_q[LEAD-1];
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cyc_q <= 8'h00;
      cycle_start <= 1'b0;
      block_in <= 1'b0;
      trip_q <= '0;
      alarm_q <= '0;
    end else begin
      cyc_q <= (cyc_q == 8'(PERIOD - 1)) ? 8'h00 : cyc_q + 8'h01;
      cycle_start <= (cyc_q == 8'h00);
      block_in <= want_block;
      trip_q <= {trip_q[LEAD-2:0], want_trip};
      alarm_q <= {alarm_q[LEAD-2:0], want_alarm};
    end
  end
endmodule : ajbel_partner
`default_nettype wire

// ---- ajbel_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ajbel_tb_top
  import ajbel_pkg::*;
;
  logic                      clk_sys, rst_b, want_block, want_trip, want_alarm, cycle_start, block_in;
  logic                      trip_pickup, alarm_pickup, allow_node_mode, reg_wr, reg_rd, irq, volt_sel_ok;
  logic                      trip_out, alarm_out, blocked_out, event_valid, node_mode_valid;
  logic [3:0]                ch_select, ch_present, reg_addr;
  logic [2:0]                setting_group, event_code, node_mode, peak;
  logic [1:0]                condition, cond_seen;
  logic [31:0]               reg_wdata, reg_rdata;
  logic [TS_W-1:0]           time_stamp, event_time;
  logic [NUM_CH*16-1:0]      ang_now, ang_20ms, volt_meas, ang_diff, volt_ratio;
  logic [7:0]                ev_seen;
  int                        fail_count, tests_run, trip_hi;
  ajbel_top #(.TRIP_HOLD(20)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .cycle_start(cycle_start),
    .block_in(block_in), .trip_pickup(trip_pickup), .alarm_pickup(alarm_pickup), .ch_select(ch_select),
    .ch_present(ch_present), .ang_now(ang_now), .ang_20ms(ang_20ms), .volt_meas(volt_meas),
    .time_stamp(time_stamp), .setting_group(setting_group), .allow_node_mode(allow_node_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trip_out(trip_out), .alarm_out(alarm_out), .blocked_out(blocked_out), .irq(irq),
    .event_valid(event_valid), .event_code(event_code), .event_time(event_time), .condition(condition),
    .volt_sel_ok(volt_sel_ok), .node_mode(node_mode), .node_mode_valid(node_mode_valid),
    .ang_diff(ang_diff), .volt_ratio(volt_ratio));
  ajbel_partner u_far (.clk_sys(clk_sys), .rst_b(rst_b), .want_block(want_block), .want_trip(want_trip),
    .want_alarm(want_alarm), .cycle_start(cycle_start), .block_in(block_in), .trip_pickup(trip_pickup),
    .alarm_pickup(alarm_pickup));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) time_stamp <= time_stamp + 64'h1;
  always @(posedge clk_sys) if (event_valid === 1'b1) ev_seen[event_code] <= 1'b1;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // Raises the chosen pick-ups ({alarm, trip, block}), watches the outputs, then drops them
  task automatic fire(input logic [2:0] w);
    int n;
    n = 0;
    trip_hi = 0;
    peak = 3'h0;
    @(posedge clk_sys);
    {want_alarm, want_trip, want_block} <= w;
    repeat (60) begin
      @(posedge clk_sys);
      #1 peak = peak | {alarm_out, trip_out, blocked_out};
      if (trip_out === 1'b1) trip_hi++;
      if (peak != 3'h0) n++;
      if (n == 3) cond_seen = condition;
    end
    @(posedge clk_sys);
    {want_alarm, want_trip, want_block} <= 3'h0;
    repeat (16) @(posedge clk_sys);
  endtask : fire
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end
  initial begin
    {rst_b, want_block, want_trip, want_alarm, allow_node_mode, reg_wr, reg_rd} = 7'h00;
    {reg_addr, reg_wdata, time_stamp, ang_now, ang_20ms, ev_seen} = '0;
    {fail_count, tests_run} = 64'h0;
    ch_select = 4'h3;
    ch_present = 4'hf;
    setting_group = 3'h2;
    volt_meas = {4{16'h2710}};
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(4'h1, 32'h251c);
    rd(4'h2, 32'hfff);
    rd(4'hd, 32'h0);
    rd(4'he, 32'h0);
    wr(4'h0, 32'h1);
    wr(4'h4, 32'h7);
    ang_now <= {32'h0, 16'h0064, 16'h01f4};
    ang_20ms <= {32'h0, 16'h012c, 16'h0064};
    repeat (4) @(posedge clk_sys);
    #1 chk(ang_diff[31:0], {16'hff38, 16'h0190});
    chk(volt_ratio[15:0], 100 * 10000 / 9500);
    chk(volt_sel_ok, 1'b1);
    ch_present <= 4'he;
    repeat (4) @(posedge clk_sys);
    #1 chk(volt_sel_ok, 1'b0);
    ch_present <= 4'hf;
    ev_seen = '0;
    fire(3'b010);
    chk({peak, trip_hi}, {3'b010, 32'd20});
    chk({cond_seen, ev_seen[3:2], irq}, {2'h2, 2'b11, 1'b1});
    rd(4'h3, 32'h82);
    rd(4'h6, 32'h1);
    wr(4'h3, 32'h7);
    fire(3'b011);
    chk({peak, cond_seen, irq}, {3'b001, 2'h1, 1'b1});
    rd(4'h7, 32'h1);
    wr(4'h3, 32'h7);
    wr(4'h4, 32'h0);
    fire(3'b100);
    chk({peak, cond_seen, irq}, {3'b100, 2'h3, 1'b0});
    rd(4'h5, 32'h1);
    wr(4'h0, 32'h0);
    fire(3'b100);
    chk(peak, 3'b000);
    volt_meas[15:0] <= 16'h2000;
    fire(3'b010);
    chk(peak, 3'b001);
    volt_meas[15:0] <= 16'h2710;
    wr(4'h2, 32'hfef);
    ev_seen = '0;
    fire(3'b010);
    chk(ev_seen[3:2], 2'b10);
    wr(4'h2, 32'hfff);
    rd(4'hd, 32'h5);
    repeat (8) fire(3'b010);
    rd(4'hd, 32'hc);
    wr(4'h9, 32'h0);
    rd(4'hf, 32'h82);
    rd(4'hc, 32'h0190ff38);
    wr(4'h8, 32'h7);
    rd(4'h5, 32'h0);
    rd(4'h6, 32'h0);
    rd(4'h7, 32'h0);
    rd(4'hd, 32'hc);
    allow_node_mode <= 1'b1;
    for (int m = 0; m < 5; m++) begin
      wr(4'h0, {25'h0, 3'(m), 4'h0});
      repeat (3) @(posedge clk_sys);
      #1 chk({node_mode_valid, node_mode}, {1'b1, 3'(m)});
    end
    allow_node_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk({node_mode_valid, node_mode}, 4'h0);
    conclude();
  end
endmodule : ajbel_tb_top
`default_nettype wire
